// ==== src/rtci_pkg.sv ====
// Shared constants and types for the RTC interrupt logic, device end and host end.
// Assumes a single 20 MHz clock and a 32.768 kHz timebase tick supplied as an enable pulse.
package rtci_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [16:0] RTCI_ADDR_EVENT_FLAGS = 17'h1_fff0;
	localparam logic [16:0] RTCI_ADDR_IRQ_CONFIG = 17'h1_fff6;

	// Flag bit positions in event_flags.
	localparam int RTCI_FLG_WDOG = 7;
	localparam int RTCI_FLG_ALARM = 6;
	localparam int RTCI_FLG_PWRFAIL = 5;
	localparam int RTCI_FLG_OSC = 4;

	// Field positions in interrupt_config.
	localparam int RTCI_CFG_WDOG_EN = 7;
	localparam int RTCI_CFG_ALARM_EN = 6;
	localparam int RTCI_CFG_PWRFAIL_EN = 5;
	localparam int RTCI_CFG_HIGH = 3;
	localparam int RTCI_CFG_PULSE = 2;

	// Writable bits of interrupt_config and its reset value.
	localparam logic [7:0] RTCI_CFG_MASK = 8'h00_ec;
	localparam logic [7:0] RTCI_CFG_RESET = 8'h00_08;
	localparam logic [7:0] RTCI_FLAGS_RESET = 8'h00_00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int RTCI_TICK_HZ = 32768;
	localparam int RTCI_PULSE_MS = 200;
	// Pulse length in timebase ticks, rounded down.
	localparam int RTCI_PULSE_TICKS = (RTCI_TICK_HZ * RTCI_PULSE_MS) / 1000;
	localparam int RTCI_PCNT_W = 13;

	typedef enum logic [2:0] {
		RTCI_ST_IDLE = 3'b001,
		RTCI_ST_LEVEL = 3'b010,
		RTCI_ST_PULSE = 3'b100
	} rtci_state_t;

	typedef enum logic [1:0] {
		RTCI_H_HOLD = 2'b01,
		RTCI_H_WAIT = 2'b10
	} rtci_hstate_t;

endpackage : rtci_pkg

// ==== src/rtci_if.sv ====
// Interface joining the RTC interrupt device end to the host end.
// Assumes the bench resolves the interrupt wire from value and enable, with a pull-up.
interface rtci_if;
	import rtci_pkg::*;

	logic rd_en;
	logic wr_en;
	logic [16:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic irq_out;
	logic irq_oe;
	logic irq_in;

	modport dev (input rd_en, input wr_en, input addr, input wdata, output rdata,
		output irq_out, output irq_oe, input irq_in);
	modport host (output rd_en, output wr_en, output addr, output wdata, input rdata,
		input irq_in);
endinterface : rtci_if

// ==== src/rtci_dev.sv ====
// Device end of the RTC interrupt logic: flags, interrupt configuration and output driver.
// Assumes event inputs are one-cycle pulses from the source logic and a timebase tick enable.
// Assumes i_tick is high for one clock per timebase period.
// Assumes the surroundings resolve the pin from its value and enable, with a pull-up.
// Function
// - Three sources each with own enable bit
// - Output needs set flag and its enable
// - Pulse mode gives fixed 200 ms pulse
// - Level mode holds until flags read
// - No interrupts while on backup power
// - Interrupts valid only after recall completes
// - Watchdog timeout sets flag, optionally interrupts
// - Alarm match sets flag, optionally interrupts
// - Power fail sets flag, optionally interrupts
// - Polarity bit selects high push-pull or low open-drain
// - Active high drive gated by power good
// - Flags read clears all flags except oscillator flag
// - Flags read ends pulse early
// - Host reads flags on interrupt
// - Host in reset does not read flags
// - Each flag except oscillator flag sticky until flags read
// - Flags pollable with interrupts disabled
// - Flags load zero on power-up except oscillator flag
module rtci_dev
	import rtci_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	rtci_if.dev bus,
	input wire logic i_tick,
	input wire logic i_wdog_timeout,
	input wire logic i_alarm_match,
	input wire logic i_pwrfail,
	input wire logic i_osc_failed,
	input wire logic i_vcc_good,
	input wire logic i_recall_done,
	output logic o_irq_active
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Everything the device end remembers, registered as one word.
	// The oscillator flag is not stored here: it follows its source level.
	typedef struct packed {
		rtci_state_t st;
		logic [7:0] cfg;
		logic wdog_timeout_flag;
		logic alarm_match_flag;
		logic pwrfail_flag;
		logic [RTCI_PCNT_W-1:0] pcnt;
		logic [7:0] rdata;
	} rtci_dev_t;

	rtci_dev_t s_reg;
	rtci_dev_t s_next;
	logic flags_rd;
	logic cfg_rd;
	logic cfg_wr;
	logic pend;
	logic active;
	logic enabled;
	logic pulse_last;
	logic high_mode;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Full address compare; the block answers only at its two offsets.
	function automatic logic addr_hit(input logic [16:0] a, input logic [16:0] r);
		return a == r;
	endfunction : addr_hit

	// A source requests the pin only while its flag and its enable are both set.
	function automatic logic src_req(input logic flag, input logic [7:0] cfg, input int pos);
		return flag && cfg[pos];
	endfunction : src_req

	function automatic logic [7:0] flags_byte(input rtci_dev_t s, input logic osc);
		logic [7:0] b;
		b = 8'h00_00;
		b[RTCI_FLG_WDOG] = s.wdog_timeout_flag;
		b[RTCI_FLG_ALARM] = s.alarm_match_flag;
		b[RTCI_FLG_PWRFAIL] = s.pwrfail_flag;
		b[RTCI_FLG_OSC] = osc;
		return b;
	endfunction : flags_byte

	// Reads of offsets outside the map return zero.
	function automatic logic [7:0] read_byte(input rtci_dev_t s, input logic osc,
		input logic fl, input logic cf);
		logic [7:0] b;
		b = 8'h00;
		if (fl) begin
			b = flags_byte(s, osc);
		end else if (cf) begin
			b = s.cfg;
		end
		return b;
	endfunction : read_byte

	// Hardware set wins over a clearing read in the same cycle, so no event is lost.
	function automatic logic sticky(input logic flag, input logic set, input logic clr);
		logic f;
		f = flag;
		if (clr) begin
			f = 1'b0;
		end
		if (set) begin
			f = 1'b1;
		end
		return f;
	endfunction : sticky

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Only the flags offset clears anything on a read.
	assign flags_rd = bus.rd_en && addr_hit(bus.addr, RTCI_ADDR_EVENT_FLAGS);
	assign cfg_rd = bus.rd_en && addr_hit(bus.addr, RTCI_ADDR_IRQ_CONFIG);
	assign cfg_wr = bus.wr_en && addr_hit(bus.addr, RTCI_ADDR_IRQ_CONFIG);
	// Backup power or an unfinished recall silences the pin and blocks new requests.
	assign enabled = i_vcc_good && i_recall_done;
	// A request stays pending while its flag is set, so a finished pulse re-arms.
	assign pend = src_req(s_reg.wdog_timeout_flag, s_reg.cfg, RTCI_CFG_WDOG_EN)
		|| src_req(s_reg.alarm_match_flag, s_reg.cfg, RTCI_CFG_ALARM_EN)
		|| src_req(s_reg.pwrfail_flag, s_reg.cfg, RTCI_CFG_PWRFAIL_EN);
	// The pulse ends on the tick that completes its count.
	assign pulse_last = i_tick && (s_reg.pcnt == RTCI_PCNT_W'(RTCI_PULSE_TICKS - 1));

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		if (bus.rd_en) begin
			s_next.rdata = read_byte(s_reg, i_osc_failed, flags_rd, cfg_rd);
		end
		if (cfg_wr) begin
			s_next.cfg = bus.wdata & RTCI_CFG_MASK;
		end
		s_next.wdog_timeout_flag = sticky(s_reg.wdog_timeout_flag, i_wdog_timeout, flags_rd);
		s_next.alarm_match_flag = sticky(s_reg.alarm_match_flag, i_alarm_match, flags_rd);
		s_next.pwrfail_flag = sticky(s_reg.pwrfail_flag, i_pwrfail, flags_rd);
		// The state only leaves idle when a request is taken.
		unique case (s_reg.st)
			RTCI_ST_IDLE: begin
				// The mode is chosen when the request is taken.
				if (pend && enabled && !flags_rd) begin
					s_next.pcnt = '0;
					s_next.st = s_reg.cfg[RTCI_CFG_PULSE] ? RTCI_ST_PULSE : RTCI_ST_LEVEL;
				end
			end
			RTCI_ST_LEVEL: begin
				// Level holds until the host reads the flags.
				if (flags_rd || !enabled) begin
					s_next.st = RTCI_ST_IDLE;
				end
			end
			RTCI_ST_PULSE: begin
				// A flags read cuts the pulse short.
				if (flags_rd || !enabled) begin
					s_next.st = RTCI_ST_IDLE;
				end else if (pulse_last) begin
					s_next.st = RTCI_ST_IDLE;
				end else if (i_tick) begin
					s_next.pcnt = s_reg.pcnt + 1'b1;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Flags clear on power-up; the oscillator flag is left to its source.
	// Clock enable low freezes every field.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_reg.st <= RTCI_ST_IDLE;
			s_reg.cfg <= RTCI_CFG_RESET;
			s_reg.wdog_timeout_flag <= RTCI_FLAGS_RESET[RTCI_FLG_WDOG];
			s_reg.alarm_match_flag <= RTCI_FLAGS_RESET[RTCI_FLG_ALARM];
			s_reg.pwrfail_flag <= RTCI_FLAGS_RESET[RTCI_FLG_PWRFAIL];
			s_reg.pcnt <= '0;
			s_reg.rdata <= 8'h00_00;
		end else if (i_ce) begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Pin driver
	// ----------------------------------------------------------------
	// High: push-pull, driven only while supply is good. Low: open drain pulls low.
	// The enable is high whenever this end drives the wire.
	assign active = (s_reg.st != RTCI_ST_IDLE) && enabled;
	assign high_mode = s_reg.cfg[RTCI_CFG_HIGH];
	assign o_irq_active = active;
	assign bus.rdata = s_reg.rdata;
	assign bus.irq_out = high_mode ? (active && i_vcc_good) : 1'b0;
	assign bus.irq_oe = high_mode ? i_vcc_good : active;

endmodule : rtci_dev

// ==== src/rtci_host.sv ====
// Host end: on an interrupt, reads the flags register and reports the causing sources.
// Assumes the interrupt wire level is resolved by the bench from the device enable.
module rtci_host
	import rtci_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	rtci_if.host bus,
	input wire logic i_high_active,
	input wire logic i_recall_done,
	input wire logic i_in_reset,
	input wire logic i_poll,
	output logic o_flags_valid,
	output logic [7:0] o_flags
);

	typedef struct packed {
		rtci_hstate_t st;
		logic rd;
		logic valid;
		logic [7:0] flags;
	} rtci_host_t;

	rtci_host_t s_reg;
	rtci_host_t s_next;
	logic irq_seen;

	always_comb begin
		s_next = s_reg;
		s_next.valid = 1'b0;
		s_next.rd = 1'b0;
		irq_seen = (bus.irq_in == i_high_active) && i_recall_done;
		unique case (s_reg.st)
			RTCI_H_HOLD: begin
				if ((irq_seen || i_poll) && !i_in_reset) begin
					s_next.rd = 1'b1;
					s_next.st = RTCI_H_WAIT;
				end
			end
			RTCI_H_WAIT: begin
				// The device answers on the same edge that takes the read.
				if (!s_reg.rd) begin
					s_next.flags = bus.rdata;
					s_next.valid = 1'b1;
					s_next.st = RTCI_H_HOLD;
				end
			end
			default: begin
				s_next.st = RTCI_H_HOLD;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_reg.st <= RTCI_H_HOLD;
			s_reg.rd <= 1'b0;
			s_reg.valid <= 1'b0;
			s_reg.flags <= 8'h00_00;
		end else if (i_ce) begin
			s_reg <= s_next;
		end
	end

	assign bus.rd_en = s_reg.rd;
	assign bus.wr_en = 1'b0;
	assign bus.addr = RTCI_ADDR_EVENT_FLAGS;
	assign bus.wdata = 8'h00_00;
	assign o_flags_valid = s_reg.valid;
	assign o_flags = s_reg.flags;

endmodule : rtci_host

// ==== testbench/rtci_props.sv ====
// Checker for the link between the device end and the host end.
// Assumes that device keeps its reset configuration and a good supply.
module rtci_props
	import rtci_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [16:0] addr,
	input wire logic [7:0] rdata,
	input wire logic irq_out,
	input wire logic irq_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_read;
		rd_en ##1 !rd_en;
	endsequence
	no_write_a: assert property (!wr_en) else $error("host wrote");
	read_addr_a: assert property (rd_en |-> addr == RTCI_ADDR_EVENT_FLAGS)
		else $error("read off flags");
	read_gap_a: assert property (rd_en |-> s_read) else $error("read too long");
	rdata_hold_a: assert property (!rd_en |=> $stable(rdata)) else $error("rdata moved");
	idle_bit_a: assert property (rd_en |=> !rdata[3]) else $error("bit3 set");
	irq_quiet_a: assert property (!irq_out) else $error("irq not enabled");
	push_pull_a: assert property (irq_oe) else $error("no drive");
	oe_out_a: assert property (!irq_oe |-> !irq_out) else $error("out w/o oe");
endmodule : rtci_props

// ==== testbench/rtci_tb.sv ====
// Bench: host end and device on one link, a second device driven by the bench.
// Assumes a pull-up on each interrupt wire.
module rtci_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rtci_pkg::*;
	logic clk = 0, rst_b = 0, ce = 1, tick = 0, vcc = 1, rec = 1, osc = 0, poll = 0;
	logic [2:0] ev = 0;
	logic fv, act;
	logic [7:0] fl;
	int n_errors = 0, num_checks = 0, k;
	logic [7:0] rc[6] = '{8'h88, 8'h48, 8'h28, 8'h68, 8'h80, 8'h00};
	int re[6] = '{2, 1, 0, 2, 2, 2};
	logic rp[6] = '{1, 1, 1, 0, 0, 1};
	logic [7:0] rf[6] = '{8'h80, 8'h40, 8'h20, 8'h80, 8'h80, 8'h80};
	rtci_if b0 ();
	rtci_if b1 ();
	assign b0.irq_in = b0.irq_oe ? b0.irq_out : 1'b1;
	assign b1.irq_in = b1.irq_oe ? b1.irq_out : 1'b1;
	always #25 clk = ~clk;
	always @(posedge clk) tick <= ~tick;
	rtci_dev rtci_dev_inst (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .bus(b0), .i_tick(tick),
		.i_wdog_timeout(ev[2]), .i_alarm_match(ev[1]), .i_pwrfail(ev[0]), .i_osc_failed(osc),
		.i_vcc_good(1'b1), .i_recall_done(rec), .o_irq_active());
	rtci_dev rtci_dev_inst_b (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .bus(b1), .i_tick(tick),
		.i_wdog_timeout(ev[2]), .i_alarm_match(ev[1]), .i_pwrfail(ev[0]), .i_osc_failed(osc),
		.i_vcc_good(vcc), .i_recall_done(rec), .o_irq_active(act));
	rtci_host rtci_host_inst (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .bus(b0),
		.i_high_active(1'b1), .i_recall_done(rec), .i_in_reset(1'b0), .i_poll(poll),
		.o_flags_valid(fv), .o_flags(fl));
	rtci_props rtci_props_inst (.i_clk(clk), .i_rst_b(rst_b), .rd_en(b0.rd_en),
		.wr_en(b0.wr_en), .addr(b0.addr), .rdata(b0.rdata), .irq_out(b0.irq_out),
		.irq_oe(b0.irq_oe));
	task automatic cyc(input int n = 1);
		repeat (n) @(posedge clk);
		#5;
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [16:0] a, input logic [7:0] exp);
		b1.rd_en = 1;
		b1.addr = a;
		cyc();
		b1.rd_en = 0;
		chk(b1.rdata, exp);
	endtask : rd
	task automatic wr(input logic [7:0] d);
		b1.wr_en = 1;
		b1.addr = RTCI_ADDR_IRQ_CONFIG;
		b1.wdata = d;
		cyc();
		b1.wr_en = 0;
	endtask : wr
	task automatic fire(input int i);
		ev[i] = 1;
		cyc();
		ev = 0;
		cyc();
	endtask : fire
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial begin
		#1_000_000;
		n_errors++;
		conclude();
	end
	initial begin
		b1.rd_en = 0;
		b1.wr_en = 0;
		b1.addr = 0;
		b1.wdata = 0;
		cyc(6);
		rst_b = 1;
		rd(RTCI_ADDR_EVENT_FLAGS, RTCI_FLAGS_RESET);
		rd(RTCI_ADDR_IRQ_CONFIG, RTCI_CFG_RESET);
		wr(8'hff);
		rd(RTCI_ADDR_IRQ_CONFIG, RTCI_CFG_MASK);
		rd(17'h1_fff1, 8'h00);
		osc = 1;
		rd(RTCI_ADDR_EVENT_FLAGS, 8'h10);
		osc = 0;
		$display("map done");
		for (int i = 0; i < 6; i++) begin
			wr(rc[i]);
			fire(re[i]);
			chk(8'(b1.irq_in), 8'(rp[i]));
			rd(RTCI_ADDR_EVENT_FLAGS, rf[i]);
			chk(8'(b1.irq_in), 8'(!rc[i][3]));
		end
		$display("rows done");
		wr(8'h8c);
		fire(2);
		cyc(13000);
		chk(8'(b1.irq_in), 8'h01);
		k = 0;
		while (b1.irq_in === 1'b1 && k < 400) begin
			cyc();
			k++;
		end
		chk(8'(k < 400), 8'h01);
		cyc(3);
		chk(8'(b1.irq_in), 8'h01);
		rd(RTCI_ADDR_EVENT_FLAGS, 8'h80);
		chk(8'(b1.irq_in), 8'h00);
		$display("pulse done");
		wr(8'h88);
		for (int j = 0; j < 2; j++) begin
			vcc = j[0];
			rec = !j[0];
			fire(2);
			chk(8'(act), 8'h00);
			chk(8'(b1.irq_oe), 8'(j[0]));
			rd(RTCI_ADDR_EVENT_FLAGS, 8'h80);
			vcc = 1;
			rec = 1;
		end
		poll = 1;
		k = 0;
		while (fv !== 1'b1 && k < 50) begin
			cyc();
			k++;
		end
		poll = 0;
		chk(fl, 8'he0);
		$display("supply and poll done");
		conclude();
	end
endmodule : rtci_tb
